// *** rtl/rtcie_core.sv ***
`timescale 1ns/1ps
module rtcie_core #(
  parameter int unsigned PULSE_SHORT_CYC = rtcie_pkg::PULSE_SHORT_CYC,
  parameter int unsigned PULSE_LONG_CYC  = rtcie_pkg::PULSE_LONG_CYC,
  parameter int unsigned PRESCALE_DIV    = rtcie_pkg::PRESCALE_DIV,
  parameter int unsigned HUND_DIV        = rtcie_pkg::HUND_DIV
) (
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_n_in,
  input  wire logic [rtcie_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [31:0]                   avs_readdata_out,
  output logic                               avs_waitrequest_out,
  input  wire logic                          countdown_event_in,
  input  wire logic                          alarm_match_in,
  input  wire logic                          ext_event_in,
  input  wire logic                          clock_output_on_in,
  input  wire logic                          update_ready_in,
  output logic                               int_pin_out,
  output logic                               int_pin_oe_out,
  output logic                               irq_out,
  output logic                               time_update_out,
  output logic                               timer_clk_en_out,
  output logic                               clock_output_pin_run_out,
  output logic                               alarm_match_en_out,
  output logic                               evi_filter_en_out,
  output logic                               temp_run_out,
  output logic                               general_purpose_out,
  output logic      [7:0]                    hundredths_out
);

  localparam int unsigned W      = rtcie_pkg::CNT_W;
  localparam int unsigned EV_N_C = rtcie_pkg::EV_N - 1;   // top index of the event vector
  localparam int unsigned CW     = rtcie_pkg::CHAIN_W;    // prescaler chain width

  // refuse counts the counters cannot hold
  if (PULSE_SHORT_CYC < 1 || PULSE_SHORT_CYC >= (1 << W) ||
      PULSE_LONG_CYC < 1 || PULSE_LONG_CYC >= (1 << W) ||
      PRESCALE_DIV < 2 || PRESCALE_DIV >= (1 << W) ||
      HUND_DIV < 2 || HUND_DIV >= (1 << W)) begin : g_bad_param
    $error("rtcie_core: count parameter out of range");
  end

  // sized copies of the counts
  localparam logic [W-1:0] SHORT_C = W'(PULSE_SHORT_CYC);
  localparam logic [W-1:0] LONG_C  = W'(PULSE_LONG_CYC);
  localparam logic [W-1:0] PDIV_L  = W'(PRESCALE_DIV - 1);
  localparam logic [W-1:0] HDIV_L  = W'(HUND_DIV - 1);

  rtcie_pkg::rtcie_state_s   st_r;    // registered state
  rtcie_pkg::rtcie_state_s   st_nxt;  // next state
  rtcie_pkg::rtcie_avs_req_s req;     // bundled bus request

  logic            stop;      // stop bit
  logic            run;       // clock chain allowed to advance
  logic            tsel_zero; // short pulse selection
  logic            alm_set;   // alarm flag event
  logic            ext_set;   // external event flag event
  logic            tmr_act;   // timer pin pulse running
  logic            any_req;   // combined pin request
  logic            sel;       // access hits a mapped word
  logic [31:0]     rd_mux;    // read data before capture
  logic [EV_N_C:0] ev;        // events into sticky status

  assign req.address    = avs_address_in;
  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.writedata  = avs_writedata_in;
  assign req.byteenable = avs_byteenable_in;

  assign stop      = st_r.ctrl[rtcie_pkg::CTRL_STOP];
  assign run       = ~stop;
  assign tsel_zero = (st_r.cfg[rtcie_pkg::CFG_TSEL_LO +: 2] == 2'h0);
  // alarm matching is frozen with the calendar while stopped
  assign alm_set   = alarm_match_in & run;
  // external event still latches while stopped, time stamp is junk then
  assign ext_set   = ext_event_in;
  assign tmr_act   = (st_r.tmr_cnt != '0);

  // wired combination of the enabled requests
  assign any_req = (tmr_act & st_r.ctrl[rtcie_pkg::CTRL_TMR_IE]) |
                   (st_r.flags[rtcie_pkg::FLG_ALM] & st_r.ctrl[rtcie_pkg::CTRL_ALM_IE]) |
                   (st_r.flags[rtcie_pkg::FLG_EXT] & st_r.ctrl[rtcie_pkg::CTRL_EXT_IE]);

  // events that feed the interrupt status register
  assign ev[rtcie_pkg::EV_EXT] = ext_set;
  assign ev[rtcie_pkg::EV_ALM] = alm_set;
  assign ev[rtcie_pkg::EV_TMR] = countdown_event_in;

  // address decode
  always_comb begin
    sel    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (req.address)
      rtcie_pkg::OFS_CTRL:     rd_mux[4:0]  = st_r.ctrl;
      rtcie_pkg::OFS_CFG:      rd_mux[2:0]  = st_r.cfg;
      rtcie_pkg::OFS_FLAGS:    rd_mux[1:0]  = st_r.flags;
      rtcie_pkg::OFS_IRQ_STAT: rd_mux[2:0]  = st_r.irq_stat;
      rtcie_pkg::OFS_IRQ_MASK: rd_mux[2:0]  = st_r.irq_mask;
      rtcie_pkg::OFS_STATE: begin
        rd_mux[rtcie_pkg::ST_HUND_LO +: 8]                   = st_r.hund_cnt;
        rd_mux[rtcie_pkg::ST_CHAIN_LO +: rtcie_pkg::CHAIN_W] = st_r.chain_cnt;
      end
      default:                 sel          = 1'b0; // unmapped reads zero
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    logic acc_wr;           // write taken at this edge
    logic acc_rd;           // read taken at this edge
    logic [EV_N_C:0] rclr;  // status bits read out now
    logic [1:0] fclr;       // flags written one
    logic wrap_4k;          // prescaler divider wraps
    logic wrap_1hz;         // chain wraps, 1 Hz update due
    acc_wr   = req.write & st_r.ack & sel & req.byteenable[0];
    acc_rd   = req.read & st_r.ack;
    rclr     = '0;
    fclr     = 2'h0;
    wrap_4k  = 1'b0;
    wrap_1hz = 1'b0;
    st_nxt   = st_r;

    // bus handshake: one wait cycle, data captured before the answer
    st_nxt.ack = (req.read | req.write) & ~st_r.ack;
    if ((req.read | req.write) & ~st_r.ack) begin
      st_nxt.rdata = req.read ? rd_mux : 32'h0000_0000;
    end
    // read clears exactly the status bits returned
    if (acc_rd && req.address == rtcie_pkg::OFS_IRQ_STAT) begin
      rclr = st_r.rdata[EV_N_C:0];
    end

    // register writes
    if (acc_wr) begin
      unique case (req.address)
        rtcie_pkg::OFS_CTRL:     st_nxt.ctrl     = req.writedata[4:0];
        rtcie_pkg::OFS_CFG:      st_nxt.cfg      = req.writedata[2:0];
        rtcie_pkg::OFS_FLAGS:    fclr            = req.writedata[1:0];
        rtcie_pkg::OFS_IRQ_MASK: st_nxt.irq_mask = req.writedata[EV_N_C:0];
        default: begin
          // read-only words ignore writes
        end
      endcase
    end

    // flags: write one clears, a same-cycle event wins
    st_nxt.flags = st_r.flags & ~fclr;
    if (alm_set) begin
      st_nxt.flags[rtcie_pkg::FLG_ALM] = 1'b1;
    end
    if (ext_set) begin
      st_nxt.flags[rtcie_pkg::FLG_EXT] = 1'b1;
    end
    // sticky status, set wins over the read clear
    st_nxt.irq_stat = (st_r.irq_stat & ~rclr) | ev;

    // prescaler chain and hundredths only advance while running
    st_nxt.tick_4k = 1'b0;
    if (stop) begin
      st_nxt.div_cnt   = '0;
      st_nxt.chain_cnt = '0;
      st_nxt.hund_div  = '0;
      st_nxt.hund_cnt  = 8'h00;
      st_nxt.upd_pend  = 1'b0;
    end else begin
      wrap_4k        = (st_r.div_cnt == PDIV_L);
      st_nxt.div_cnt = wrap_4k ? '0 : st_r.div_cnt + W'(1);
      st_nxt.tick_4k = wrap_4k;
      if (wrap_4k) begin
        wrap_1hz         = (st_r.chain_cnt == '1);
        st_nxt.chain_cnt = st_r.chain_cnt + CW'(1);
      end
      if (st_r.hund_div == HDIV_L) begin
        st_nxt.hund_div = '0;
        st_nxt.hund_cnt = (st_r.hund_cnt == rtcie_pkg::HUND_LAST) ? 8'h00 : st_r.hund_cnt + 8'h01;
      end else begin
        st_nxt.hund_div = st_r.hund_div + W'(1);
      end
      // update waits for the time counters to accept it
      if (wrap_1hz) begin
        st_nxt.upd_pend = 1'b1;
      end else if (st_r.upd_pend & update_ready_in) begin
        st_nxt.upd_pend = 1'b0;
      end
    end
    // stale update never escapes once stop is set
    st_nxt.upd_pulse = run & st_r.upd_pend & update_ready_in;

    // timer pin pulse: load on event, count down, cancel on disable
    if (!st_r.ctrl[rtcie_pkg::CTRL_TMR_IE]) begin
      st_nxt.tmr_cnt = '0;
    end else if (countdown_event_in) begin
      st_nxt.tmr_cnt = tsel_zero ? SHORT_C : LONG_C;
    end else if (tmr_act) begin
      st_nxt.tmr_cnt = st_r.tmr_cnt - W'(1);
    end

    // pin drive, optionally held off until the clock output is on
    st_nxt.int_oe = any_req & (~st_r.cfg[rtcie_pkg::CFG_DLY] | clock_output_on_in);
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r          <= '0;
      st_r.ctrl     <= rtcie_pkg::CTRL_RST;
      st_r.cfg      <= rtcie_pkg::CFG_RST;
      st_r.irq_mask <= rtcie_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign avs_waitrequest_out = (req.read | req.write) & ~st_r.ack;
  assign avs_readdata_out    = st_r.rdata;
  // open-drain pin only ever pulls low
  assign int_pin_out         = 1'b0;
  assign int_pin_oe_out      = st_r.int_oe;
  assign irq_out             = |(st_r.irq_stat & st_r.irq_mask);
  assign time_update_out     = st_r.upd_pulse;
  // frozen functions follow the registered stop bit; the registered timer tick stops one cycle after it
  assign timer_clk_en_out    = st_r.tick_4k;
  assign clock_output_pin_run_out      = run;
  assign alarm_match_en_out  = run;
  assign evi_filter_en_out   = run;
  assign temp_run_out        = run;
  assign general_purpose_out = st_r.ctrl[rtcie_pkg::CTRL_GP];
  assign hundredths_out      = st_r.hund_cnt;

endmodule : rtcie_core

// *** rtl/rtcie_pkg.sv ***
package rtcie_pkg;
  // clock and timing figures in their own units
  localparam int unsigned CLK_HZ          = 200_000_000;     // system clock rate
  // times kept in nanoseconds so the long pulse still fits 32 bits
  localparam int unsigned CLK_PERIOD_NS   = 5;               // 5 ns
  localparam int unsigned PRESCALE_HZ     = 4_096;           // top stage of the prescaler chain
  localparam int unsigned HUND_HZ         = 100;             // hundredths rate
  localparam int unsigned PULSE_SHORT_NS  = 122_000;         // 122 us, timer clock select 00
  localparam int unsigned PULSE_LONG_NS   = 7_813_000;       // 7.813 ms, other selections
  // derived cycle counts; a longest time rounds down
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_DIV    = CLK_HZ / PRESCALE_HZ;
  localparam int unsigned HUND_DIV        = CLK_HZ / HUND_HZ;
  localparam int unsigned CNT_W           = 21;              // wide enough for every divider
  localparam int unsigned CHAIN_W         = 12;              // 4096 Hz down to 1 Hz
  localparam logic [7:0]  HUND_LAST       = 8'h63;           // 99

  // register byte addresses
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  OFS_CTRL        = 5'h00;
  localparam logic [4:0]  OFS_CFG         = 5'h04;
  localparam logic [4:0]  OFS_FLAGS       = 5'h08;
  localparam logic [4:0]  OFS_IRQ_STAT    = 5'h0c;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h10;
  localparam logic [4:0]  OFS_STATE       = 5'h14;

  // control register field positions
  localparam int unsigned CTRL_STOP       = 0;
  localparam int unsigned CTRL_GP         = 1;
  localparam int unsigned CTRL_EXT_IE     = 2;
  localparam int unsigned CTRL_ALM_IE     = 3;
  localparam int unsigned CTRL_TMR_IE     = 4;
  // config register field positions
  localparam int unsigned CFG_DLY         = 0;
  localparam int unsigned CFG_TSEL_LO     = 1;
  // flag and interrupt bit positions
  localparam int unsigned FLG_EXT         = 0;
  localparam int unsigned FLG_ALM         = 1;
  localparam int unsigned EV_EXT          = 0;
  localparam int unsigned EV_ALM          = 1;
  localparam int unsigned EV_TMR          = 2;
  localparam int unsigned EV_N            = 3;
  // state register field positions
  localparam int unsigned ST_HUND_LO      = 0;
  localparam int unsigned ST_CHAIN_LO     = 8;

  // reset values
  localparam logic [4:0]  CTRL_RST        = 5'h00;
  localparam logic [2:0]  CFG_RST         = 3'h0;
  localparam logic [2:0]  MASK_RST        = 3'h0;

  // avalon slave request
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } rtcie_avs_req_s;

  // whole block state
  typedef struct packed {
    logic [4:0]         ctrl;      // stop, gp, enables
    logic [2:0]         cfg;       // delay enable, timer clock select
    logic [1:0]         flags;     // alarm and external event flags
    logic [EV_N-1:0]    irq_stat;  // sticky, read clears
    logic [EV_N-1:0]    irq_mask;
    logic [CNT_W-1:0]   div_cnt;   // 4096 Hz divider
    logic [CHAIN_W-1:0] chain_cnt; // 4096 Hz .. 1 Hz stages
    logic [CNT_W-1:0]   hund_div;
    logic [7:0]         hund_cnt;
    logic               tick_4k;
    logic               upd_pend;  // latched 1 Hz update
    logic               upd_pulse;
    logic [CNT_W-1:0]   tmr_cnt;   // timer pin pulse remaining
    logic               int_oe;
    logic               ack;
    logic [31:0]        rdata;
  } rtcie_state_s;
endpackage : rtcie_pkg

// *** tb/rtcie_host_model.sv ***
`timescale 1ns/1ps
// host side of the interrupt line: pull-up, measures each low stretch
module rtcie_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        int_pin_out,
  input  wire logic        int_pin_oe_out,
  output logic             int_line_out,
  output logic [31:0]      low_len_out
);
  logic [31:0] run_cnt; // cycles low so far
  // released line floats up to the pull-up
  assign int_line_out = int_pin_oe_out ? int_pin_out : 1'h1;
  // latch width of the last finished low pulse
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_cnt <= 32'h0;
      low_len_out <= 32'h0;
    end else if (int_line_out == 1'h0) begin
      run_cnt <= run_cnt + 32'h1;
    end else begin
      if (run_cnt != 32'h0) low_len_out <= run_cnt;
      run_cnt <= 32'h0;
    end
  end
endmodule : rtcie_host_model

// *** tb/rtcie_properties.sv ***
`timescale 1ns/1ps
module rtcie_properties (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic       int_pin_out,
  input wire logic       time_update_out,
  input wire logic       timer_clk_en_out,
  input wire logic       clock_output_pin_run_out,
  input wire logic       alarm_match_en_out,
  input wire logic       evi_filter_en_out,
  input wire logic       temp_run_out,
  input wire logic [7:0] hundredths_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // two stopped cycles, so registered outputs have had an edge to settle
  sequence stopped_s;
    !clock_output_pin_run_out ##1 !clock_output_pin_run_out;
  endsequence
  // request in its first cycle
  sequence req_s;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  hund_hold_a: assert property (stopped_s |-> hundredths_out == 8'h00)
    else $error("hundredths not held at zero while stopped");
  no_update_a: assert property (stopped_s |-> !time_update_out)
    else $error("time update while stopped");
  tick_freeze_a: assert property (stopped_s |-> !timer_clk_en_out)
    else $error("timer tick while stopped");
  run_levels_a: assert property (alarm_match_en_out == clock_output_pin_run_out && evi_filter_en_out == clock_output_pin_run_out
    && temp_run_out == clock_output_pin_run_out)
    else $error("run enables disagree");
  pin_data_a: assert property (int_pin_out == 1'h0)
    else $error("interrupt pin data not low");
  hund_range_a: assert property (hundredths_out <= 8'h63)
    else $error("hundredths above 99");
  wait_one_a: assert property (req_s |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  update_once_a: assert property ($rose(time_update_out) |=> !time_update_out)
    else $error("update pulse longer than one cycle");
endmodule : rtcie_properties
bind rtcie_core rtcie_properties chk_u (.clk_sys_in, .rst_n_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .int_pin_out, .time_update_out, .timer_clk_en_out, .clock_output_pin_run_out,
  .alarm_match_en_out, .evi_filter_en_out, .temp_run_out, .hundredths_out);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam int SHORT_N = 20, LONG_N = 50; // shortened pulse widths
  logic        clk_sys_in = 1'h0, rst_n_in = 1'h0;
  logic [4:0]  avs_address_in = 5'h00;
  logic        avs_read_in = 1'h0, avs_write_in = 1'h0, clock_output_on_in = 1'h1, update_ready_in = 1'h1;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, low_len_out, rd_v;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [2:0]  ev_v = 3'h0; // timer, alarm, external event pulses
  logic        avs_waitrequest_out, int_pin_out, int_pin_oe_out, irq_out, time_update_out, timer_clk_en_out;
  logic        clock_output_pin_run_out, alarm_match_en_out, evi_filter_en_out, temp_run_out, general_purpose_out;
  logic        int_line_out;
  logic [7:0]  hundredths_out;
  int          num_errors = 0, samples_checked = 0, n;
  rtcie_core #(.PULSE_SHORT_CYC(SHORT_N), .PULSE_LONG_CYC(LONG_N), .PRESCALE_DIV(4), .HUND_DIV(8)) dut_u (
    .clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .countdown_event_in(ev_v[2]),
    .alarm_match_in(ev_v[1]), .ext_event_in(ev_v[0]), .clock_output_on_in, .update_ready_in, .int_pin_out,
    .int_pin_oe_out, .irq_out, .time_update_out, .timer_clk_en_out, .clock_output_pin_run_out, .alarm_match_en_out,
    .evi_filter_en_out, .temp_run_out, .general_purpose_out, .hundredths_out);
  rtcie_host_model host_u (.clk_sys_in, .rst_n_in, .int_pin_out, .int_pin_oe_out, .int_line_out, .low_len_out);
  // 200 MHz clock
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one request, held until the rising edge that sees waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge clk_sys_in);
    end while (avs_waitrequest_out !== 1'h0);
    rd_v = avs_readdata_out;
    avs_read_in <= 1'h0;
    avs_write_in <= 1'h0;
  endtask : bus
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd_v, exp);
  endtask : rdchk
  // one-cycle event pulse
  task automatic ev(input logic [2:0] m);
    @(posedge clk_sys_in) ev_v <= m;
    @(posedge clk_sys_in) ev_v <= 3'h0;
  endtask : ev
  // release a latched update and count the pulses that follow
  task automatic cnt_upd(output int c);
    c = 0;
    @(posedge clk_sys_in) update_ready_in <= 1'h1;
    repeat (20) @(negedge clk_sys_in) c += time_update_out;
    @(posedge clk_sys_in) update_ready_in <= 1'h0;
  endtask : cnt_upd
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // hang guard, well past the longest test sequence
  initial begin
    #300000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    // reset values, unmapped address, general purpose bit
    rdchk(5'h00, 32'h0);
    rdchk(5'h04, 32'h0);
    rdchk(5'h10, 32'h0);
    rdchk(5'h18, 32'h0);
    bus(1'h1, 5'h00, 32'h2);
    rdchk(5'h00, 32'h2);
    chk(general_purpose_out, 32'h1);
    bus(1'h1, 5'h10, 32'h7);
    $display("register test done");
    // timer pulse width per clock select
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, 5'h04, 32'(s * 2));
      bus(1'h1, 5'h00, 32'h10);
      ev(3'h4);
      repeat (LONG_N + 10) @(posedge clk_sys_in);
      chk(low_len_out, s ? LONG_N : SHORT_N);
    end
    chk(irq_out, 32'h1);
    rdchk(5'h0c, 32'h4);
    rdchk(5'h0c, 32'h0);
    chk(irq_out, 32'h0);
    $display("timer test done");
    // alarm holds the line until its flag is cleared
    bus(1'h1, 5'h00, 32'h08);
    ev(3'h2);
    repeat (5) @(posedge clk_sys_in);
    chk(int_line_out, 32'h0);
    bus(1'h1, 5'h08, 32'h2);
    repeat (3) @(posedge clk_sys_in);
    chk(int_line_out, 32'h1);
    rdchk(5'h0c, 32'h2);
    $display("alarm test done");
    // delay option: external event held off until clock output runs
    bus(1'h1, 5'h04, 32'h1);
    bus(1'h1, 5'h00, 32'h04);
    clock_output_on_in <= 1'h0;
    ev(3'h1);
    repeat (10) @(posedge clk_sys_in);
    chk(int_line_out, 32'h1);
    clock_output_on_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    chk(int_line_out, 32'h0);
    bus(1'h1, 5'h08, 32'h1);
    rdchk(5'h0c, 32'h1);
    bus(1'h1, 5'h04, 32'h0);
    $display("delay test done");
    // update released normally, then a latched one dropped by stop
    update_ready_in <= 1'h0;
    repeat (17000) @(posedge clk_sys_in);
    cnt_upd(n);
    chk(n, 32'h1);
    repeat (17000) @(posedge clk_sys_in);
    bus(1'h1, 5'h00, 32'h05);
    cnt_upd(n);
    chk(n, 32'h0);
    rdchk(5'h14, 32'h0);
    chk(clock_output_pin_run_out, 32'h0);
    chk({alarm_match_en_out, evi_filter_en_out, temp_run_out}, 32'h0);
    ev(3'h2);
    ev(3'h1);
    repeat (3) @(posedge clk_sys_in);
    rdchk(5'h0c, 32'h1);
    chk(int_line_out, 32'h0);
    // restart: the dropped update must not come back
    bus(1'h1, 5'h00, 32'h04);
    cnt_upd(n);
    chk(n, 32'h0);
    $display("stop test done");
    summarize();
  end
endmodule : tb
